// File: rtl/ptmr_regs.svh
/*
  Register offsets, field positions, reset values and timing for the
  8-bit period timer.
  Assumes inclusion by bare name from the timer's design files.
*/
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PTMR_OFF_COUNT      8'h00
`define PTMR_OFF_PERIOD     8'h04
`define PTMR_OFF_CONTROL    8'h08
`define PTMR_OFF_FLAG       8'h0C
`define PTMR_OFF_ENABLE     8'h10
`define PTMR_OFF_INTCTL     8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTMR_CTL_PRE_LSB    0
`define PTMR_CTL_PRE_MSB    1
`define PTMR_CTL_RUN_BIT    2
`define PTMR_CTL_POST_LSB   3
`define PTMR_CTL_POST_MSB   6
`define PTMR_FLAG_BIT       1
`define PTMR_ENA_BIT        1
`define PTMR_GIE_BIT        7
`define PTMR_PERIPHERAL_IRQ_ENABLE_BIT       6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTMR_RST_COUNT      8'h00
`define PTMR_RST_PERIOD     8'hFF
`define PTMR_RST_CONTROL    8'h00
`define PTMR_CTL_MASK       8'h7F

// ----------------------------------------------------------------
// Timing: instruction clock is one quarter of the oscillator
// ----------------------------------------------------------------
`define PTMR_INSTR_DIV      4
`define PTMR_PRE_DIV_MID    4
`define PTMR_PRE_DIV_HIGH   16

`endif

// File: rtl/ptmr_pkg.sv
/*
  Types shared by the period timer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ptmr_pkg;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic       timer_run;
    logic [1:0] prescale_select;
  } ptmr_ctl_type;

  typedef enum logic [1:0] {
    PTMR_RD_IDLE = 2'b00,
    PTMR_RD_RESP = 2'b01
  } ptmr_rd_type;

  typedef enum logic [1:0] {
    PTMR_WR_IDLE = 2'b00,
    PTMR_WR_RESP = 2'b01
  } ptmr_wr_type;

endpackage

// File: rtl/ptmr_prescale.sv
/*
  Prescaler for the period timer: divides the instruction-clock tick
  by 1, 4 or 16 and emits one tick pulse per output period.
  Assumes tick_in is a one-cycle pulse in the sys_clk domain.
*/
`timescale 1ns/1ps
`include "ptmr_regs.svh"
`default_nettype none

module ptmr_prescale
  import ptmr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] prescale_select,
  output logic            tick_out
);

  logic [3:0] pre_count;
  logic [3:0] pre_last;

  // ---------------------------------------------------------------
  // Division ratio
  // ---------------------------------------------------------------
  // ratio select
  always_comb begin
    unique case (prescale_select)
      2'b00:   pre_last = 4'h0;
      2'b01:   pre_last = 4'(`PTMR_PRE_DIV_MID - 1);
      default: pre_last = 4'(`PTMR_PRE_DIV_HIGH - 1);
    endcase
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // cleared on request
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clear) begin
      pre_count <= 4'h0;
    end else if (tick_in) begin
      if (pre_count >= pre_last) begin
        pre_count <= 4'h0;
      end else begin
        pre_count <= pre_count + 4'h1;
      end
    end
  end

  assign tick_out = tick_in && (pre_count >= pre_last);

endmodule
`default_nettype wire

// File: rtl/ptmr_top.sv
/*
  8-bit period timer with prescaler, postscaler, interrupt flag and an
  AXI4-Lite register slave.
  Assumes a single 200 MHz sys_clk, synchronous active-high sys_rst and
  a master that keeps AXI4-Lite handshake rules.
*/
// What this block does
// - The timer runs from a quarter-rate tick of sys_clk via the prescaler.
// - Control bits 1-0 select division by 1 (00), 4 (01) or 16 (1x).
// - The count register increments once per prescaler output pulse.
// - When count equals period, the next increment returns the count to zero.
// - Each match steps the postscaler, ratio 1 to 16 from control bits 6-3.
// - Each postscaler output sets the match interrupt flag.
// - Software may read and write count and period at any time.
// - Reset loads count with zero and period with all ones.
// - The timer counts only while control bit 2 is one.
// - Writes to count or control, and reset, clear prescaler and postscaler.
// - A control write leaves the count unchanged.
`timescale 1ns/1ps
`include "ptmr_regs.svh"
`default_nettype none

module ptmr_top
  import ptmr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [7:0]             timer_count_out,
  output logic                   match_pulse,
  output logic                   irq
);

  // Offsets need five bits; the decode widens to sixteen at most
  if (ADDR_W < 5 || ADDR_W > 16) begin : g_addr_w_bad
    $error("ADDR_W out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]        timer_count;
  logic [7:0]        period_value;
  ptmr_ctl_type      timer_control;
  logic              match_irq_flag;
  logic              match_irq_enable;
  logic              global_irq_enable;
  logic              peripheral_irq_enable;
  logic [1:0]        instr_phase;
  logic              instr_tick;
  logic              pre_tick;
  logic [3:0]        post_count;
  logic              post_out;
  logic              scaler_clear;
  ptmr_wr_type       wr_state;
  ptmr_rd_type       rd_state;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              wr_lane0;
  logic              wr_count_hit;
  logic              wr_ctl_hit;
  logic              wr_flag_hit;
  logic [7:0]        next_count;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        off);
    return 16'(a) == 16'(off);
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return addr_is(a, `PTMR_OFF_COUNT) || addr_is(a, `PTMR_OFF_PERIOD)
        || addr_is(a, `PTMR_OFF_CONTROL) || addr_is(a, `PTMR_OFF_FLAG)
        || addr_is(a, `PTMR_OFF_ENABLE) || addr_is(a, `PTMR_OFF_INTCTL);
  endfunction

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  // Address and data are caught independently, in either order
  assign s_axi_awready = (wr_state == PTMR_WR_IDLE) && !aw_held;
  assign s_axi_wready  = (wr_state == PTMR_WR_IDLE) && !w_held;
  assign wr_fire       = (wr_state == PTMR_WR_IDLE) && aw_held && w_held;
  assign wr_lane0      = wr_fire && w_strb[0];
  assign wr_count_hit  = wr_lane0 && addr_is(aw_addr, `PTMR_OFF_COUNT);
  assign wr_ctl_hit    = wr_lane0 && addr_is(aw_addr, `PTMR_OFF_CONTROL);
  assign wr_flag_hit   = wr_lane0 && addr_is(aw_addr, `PTMR_OFF_FLAG);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_state     <= PTMR_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      unique case (wr_state)
        PTMR_WR_IDLE: begin
          if (wr_fire) begin
            wr_state     <= PTMR_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr) ? 2'b00 : 2'b10;
          end
        end
        PTMR_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= PTMR_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state <= PTMR_WR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------
  // period write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      period_value <= `PTMR_RST_PERIOD;
    end else if (wr_lane0 && addr_is(aw_addr, `PTMR_OFF_PERIOD)) begin
      period_value <= w_data[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_control <= ptmr_ctl_type'(7'(`PTMR_RST_CONTROL));
    end else if (wr_ctl_hit) begin
      timer_control <= ptmr_ctl_type'(w_data[6:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      match_irq_enable      <= 1'b0;
      global_irq_enable     <= 1'b0;
      peripheral_irq_enable <= 1'b0;
    end else begin
      if (wr_lane0 && addr_is(aw_addr, `PTMR_OFF_ENABLE)) begin
        match_irq_enable <= w_data[`PTMR_ENA_BIT];
      end
      if (wr_lane0 && addr_is(aw_addr, `PTMR_OFF_INTCTL)) begin
        global_irq_enable     <= w_data[`PTMR_GIE_BIT];
        peripheral_irq_enable <= w_data[`PTMR_PERIPHERAL_IRQ_ENABLE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  // quarter-rate tick
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      instr_phase <= 2'b00;
    end else begin
      instr_phase <= instr_phase + 2'b01;
    end
  end

  assign instr_tick = timer_control.timer_run
                   && (instr_phase == 2'(`PTMR_INSTR_DIV - 1));

  assign scaler_clear = wr_count_hit || wr_ctl_hit;

  ptmr_prescale u_prescale (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .clear           (scaler_clear),
    .tick_in         (instr_tick),
    .prescale_select (timer_control.prescale_select),
    .tick_out        (pre_tick)
  );

  // ---------------------------------------------------------------
  // Count and match
  // ---------------------------------------------------------------
  // wrap after match
  assign match_pulse = pre_tick && (timer_count == period_value);

  always_comb begin
    next_count = timer_count;
    if (pre_tick) begin
      next_count = match_pulse ? 8'h00 : timer_count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_count <= `PTMR_RST_COUNT;
    end else if (wr_count_hit) begin
      timer_count <= w_data[7:0];
    end else begin
      timer_count <= next_count;
    end
  end

  assign timer_count_out = timer_count;

  // ---------------------------------------------------------------
  // Postscaler and flag
  // ---------------------------------------------------------------
  // postscale steps on match
  assign post_out = match_pulse
                 && (post_count >= timer_control.postscale_select);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || scaler_clear) begin
      post_count <= 4'h0;
    end else if (match_pulse) begin
      post_count <= post_out ? 4'h0 : post_count + 4'h1;
    end
  end

  // write zero clears, a one sets
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      match_irq_flag <= 1'b0;
    end else if (post_out) begin
      match_irq_flag <= 1'b1;
    end else if (wr_flag_hit) begin
      match_irq_flag <= w_data[`PTMR_FLAG_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= match_irq_flag && match_irq_enable
          && peripheral_irq_enable && global_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = (rd_state == PTMR_RD_IDLE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_state     <= PTMR_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      unique case (rd_state)
        PTMR_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state     <= PTMR_RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_known(s_axi_araddr) ? 2'b00 : 2'b10;
            s_axi_rdata  <= 32'h0000_0000;
            if (addr_is(s_axi_araddr, `PTMR_OFF_COUNT)) begin
              s_axi_rdata[7:0] <= timer_count;
            end
            if (addr_is(s_axi_araddr, `PTMR_OFF_PERIOD)) begin
              s_axi_rdata[7:0] <= period_value;
            end
            if (addr_is(s_axi_araddr, `PTMR_OFF_CONTROL)) begin
              s_axi_rdata[6:0] <= timer_control;
            end
            if (addr_is(s_axi_araddr, `PTMR_OFF_FLAG)) begin
              s_axi_rdata[`PTMR_FLAG_BIT] <= match_irq_flag;
            end
            if (addr_is(s_axi_araddr, `PTMR_OFF_ENABLE)) begin
              s_axi_rdata[`PTMR_ENA_BIT] <= match_irq_enable;
            end
            if (addr_is(s_axi_araddr, `PTMR_OFF_INTCTL)) begin
              s_axi_rdata[`PTMR_GIE_BIT]  <= global_irq_enable;
              s_axi_rdata[`PTMR_PERIPHERAL_IRQ_ENABLE_BIT] <= peripheral_irq_enable;
            end
          end
        end
        PTMR_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state     <= PTMR_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: rd_state <= PTMR_RD_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: test/ptmr_checker.sv
/*
  Checker for the period timer: bus handshakes and count behaviour.
  Assumes it is bound to ptmr_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module ptmr_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  timer_count_out,
  input wire logic        match_pulse,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_arblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  // Only judged with the write path idle, a bus write may override
  property p_wrap;
    match_pulse && s_axi_awready && s_axi_wready |=> timer_count_out == 8'h00;
  endproperty
  property p_step;
    $changed(timer_count_out) && $past(s_axi_awready) |->
      timer_count_out == $past(timer_count_out) + 8'h01 ||
      timer_count_out == 8'h00;
  endproperty
  property p_pace;
    timer_count_out == $past(timer_count_out) + 8'h01 && $past(s_axi_awready)
      |=> ($stable(timer_count_out) || !$past(s_axi_awready))[*3];
  endproperty

  a_bhold:   assert property (p_bhold) else $error("b dropped");
  a_rhold:   assert property (p_rhold) else $error("r dropped");
  a_rlat:    assert property (p_rlat) else $error("read late");
  a_arblock: assert property (p_arblock) else $error("ar busy");
  a_wlat:    assert property (p_wlat) else $error("write wrong");
  a_wrap:    assert property (p_wrap) else $error("no wrap");
  a_step:    assert property (p_step) else $error("count jumped");
  a_pace:    assert property (p_pace) else $error("count fast");

  c_match: cover property (match_pulse);
  c_irq:   cover property ($rose(irq));
  c_err:   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind ptmr_top ptmr_checker u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_count_out(timer_count_out), .match_pulse(match_pulse), .irq(irq)
);
`default_nettype wire

// File: test/ptmr_top_tb.sv
/*
  Register-level bench for the period timer.
  Assumes the checker file is compiled beside it and binds itself.
*/
`timescale 1ns/1ps
`include "ptmr_regs.svh"
`default_nettype none

module ptmr_top_tb;
  localparam logic [7:0] a_cnt = `PTMR_OFF_COUNT;
  localparam logic [7:0] a_per = `PTMR_OFF_PERIOD;
  localparam logic [7:0] a_ctl = `PTMR_OFF_CONTROL;
  localparam logic [7:0] a_flg = `PTMR_OFF_FLAG;
  logic        sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, cnt_seen;
  logic [31:0] wdata, rdv;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, match_pulse, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  cnt;
  int          n_mismatch = 0;
  int          checks = 0;
  int          dv;

  ptmr_top DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_count_out(cnt), .match_pulse(match_pulse),
    .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus tasks: handshakes judged at the falling edge, acted on at rising
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge sys_clk);
      if (awvalid && awready) aw_ok = 1'b1;
      if (wvalid && wready) w_ok = 1'b1;
      b_ok = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(negedge sys_clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rdv = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk("bresp", {30'h0, resp}, 32'h0000_0000);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    rd(a);
    chk(nm, rdv, e);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk("count", a_cnt, 32'h0000_0000);
    rchk("period", a_per, 32'h0000_00FF);
    rchk("control", a_ctl, 32'h0000_0000);
    rd(8'h18);
    chk("unmapped rresp", {30'h0, resp}, 32'h0000_0002);
    wr(8'h18, 32'h0000_0001);
    chk("unmapped bresp", {30'h0, resp}, 32'h0000_0002);
    wok(a_per, 32'hFFFF_FF5A);
    rchk("period", a_per, 32'h0000_005A);
    wok(a_cnt, 32'h0000_0033);
    wok(a_ctl, 32'h0000_0080);
    rchk("control bit7", a_ctl, 32'h0000_0000);
    repeat (40) @(posedge sys_clk);
    rchk("stopped count", a_cnt, 32'h0000_0033);
    // Phase of the quarter-rate tick is free, so allow one step of slack
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wok(a_cnt, 32'h0000_0000);
      wok(a_ctl, {29'h0, 1'b1, c[1:0]});
      repeat (32 * dv - 4) @(posedge sys_clk);
      wok(a_ctl, {29'h0, 1'b0, c[1:0]});
      rd(a_cnt);
      chk("count rate", {31'h0, rdv >= 7 && rdv <= 9}, 32'h0000_0001);
      wok(a_ctl, {25'h0, 4'hF, 1'b0, c[1:0]});
      rchk("count kept", a_cnt, rdv);
    end
    wok(a_per, 32'h0000_0003);
    for (int p = 0; p < 16; p++) begin
      wok(a_ctl, 32'h0000_0000);
      wok(a_cnt, 32'h0000_0000);
      wok(a_flg, 32'h0000_0000);
      wok(a_ctl, {25'h0, p[3:0], 3'b100});
      repeat (16 * p + 4) @(posedge sys_clk);
      rchk("flag early", a_flg, 32'h0000_0000);
      repeat (14) @(posedge sys_clk);
      rchk("flag set", a_flg, 32'h0000_0002);
      rd(a_cnt);
      chk("count wrap", {31'h0, rdv <= 3}, 32'h0000_0001);
    end
    wok(a_ctl, 32'h0000_0000);
    wok(`PTMR_OFF_ENABLE, 32'h0000_0002);
    // Registered outputs are looked at half a cycle after their edge
    @(negedge sys_clk);
    chk("irq gated", {31'h0, irq}, 32'h0000_0000);
    wok(`PTMR_OFF_INTCTL, 32'h0000_00C0);
    repeat (2) @(negedge sys_clk);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    wok(`PTMR_OFF_INTCTL, 32'h0000_0080);
    repeat (2) @(negedge sys_clk);
    chk("irq no periph", {31'h0, irq}, 32'h0000_0000);
    wok(`PTMR_OFF_INTCTL, 32'h0000_00C0);
    rchk("flag kept", a_flg, 32'h0000_0002);
    wok(a_flg, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    // Count write mid-way through a 1:16 prescale must restart it
    wok(a_per, 32'h0000_00FF);
    wok(a_ctl, 32'h0000_0006);
    repeat (32) @(posedge sys_clk);
    wok(a_cnt, 32'h0000_0010);
    repeat (52) @(negedge sys_clk);
    cnt_seen = cnt;
    chk("count no step", {24'h0, cnt_seen}, 32'h0000_0010);
    repeat (16) @(negedge sys_clk);
    cnt_seen = cnt;
    chk("count stepped", {24'h0, cnt_seen}, 32'h0000_0011);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk("count", a_cnt, 32'h0000_0000);
    rchk("period", a_per, 32'h0000_00FF);
    end_of_test();
  end

  // Whole run is a few thousand cycles; this is far past it
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
